// [core/trgseq_pkg.sv]
// Summary of operation
// - abort cancels triggers, restores pending levels
// - abort clears the wait trigger flag, except when continuous mode re-arms transient
// - wait flag is operation condition bit 5
// - continuous mode re-arms right after abort
// - abort at power-on, recall and reset
// - sequence 1 transient default, 2 acquire
// - initiate arms; source event fires action
// - triggers ignored while sequence not armed
// - continuous setting 1 re-arms; 0 needs initiate
// - armed bus trigger starts pending level change
// - wait flag is OR of both armed states
// - continuous mode re-arms transient after completion
// - transient source is bus only, default bus
// - acquire trigger measures selected input into buffer
// - current and voltage counts 1..100, reset 1
// - voltmeter input count fixed at 1
// - band is level plus/minus half hysteresis
// - positive trigger: below lower, then above upper
// - negative trigger: above upper, then below lower
package trgseq_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CONT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_FUNC = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CNT_CURR = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CNT_VOLT = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CNT_AUX = 4'h5;
    localparam logic [ADDR_W-1:0] REG_HYST = 4'h6;
    localparam logic [ADDR_W-1:0] REG_LEVEL = 4'h7;
    localparam logic [ADDR_W-1:0] REG_ACQ_CFG = 4'h8;
    localparam logic [ADDR_W-1:0] REG_OPER_COND = 4'h9;
    localparam logic [ADDR_W-1:0] REG_ACQ_STAT = 4'hA;
    localparam logic [ADDR_W-1:0] REG_BUF_INDEX = 4'hB;
    localparam logic [ADDR_W-1:0] REG_BUF_DATA = 4'hC;
    // command register bits
    localparam int CMD_ABORT = 0;
    localparam int CMD_INIT_SEQ1 = 1;
    localparam int CMD_INIT_SEQ2 = 2;
    localparam int CMD_TRIG_SEQ1 = 3;
    localparam int CMD_TRIG_SEQ2 = 4;
    localparam int CMD_RESET = 5;
    localparam int CMD_RECALL = 6;
    localparam int WAIT_FLAG_BIT = 5;
    localparam int ARM_TRAN_BIT = 0;
    localparam int ARM_ACQ_BIT = 1;
    localparam int CNT_LSB = 8;
    localparam logic [6:0] CNT_MIN = 7'h01;
    localparam logic [6:0] CNT_MAX = 7'h64;
    localparam logic [6:0] CNT_AUX = 7'h01;
    localparam logic [15:0] HYST_RST = 16'h0000;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam int BUF_DEPTH = 128;
    localparam int BUF_AW = 7;
    typedef enum logic [1:0] {FN_VOLT, FN_CURR, FN_AUX} trgseq_func_t;
    typedef enum logic [1:0] {SL_POS, SL_NEG, SL_EITHER} trgseq_slope_t;
    typedef enum logic {SRC_INTERNAL, SRC_BUS} trgseq_src_t;
    typedef struct packed {
        trgseq_slope_t slope;
        trgseq_src_t source;
    } trgseq_acq_cfg_t;
    typedef struct packed {
        trgseq_func_t func;
        logic [DATA_W-1:0] value;
    } trgseq_meas_t;
endpackage

// [core/trgseq_top.sv]
`timescale 1ns/1ps
module trgseq_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [trgseq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [trgseq_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [trgseq_pkg::DATA_W-1:0] reg_rdata,
    // measured quantities
    input wire logic [trgseq_pkg::DATA_W-1:0] volt_sample,
    input wire logic [trgseq_pkg::DATA_W-1:0] curr_sample,
    input wire logic [trgseq_pkg::DATA_W-1:0] aux_voltmeter_input,
    // output level control and measurement record
    output logic level_apply,
    output logic level_restore,
    output logic meas_strobe,
    output trgseq_pkg::trgseq_meas_t meas_rec,
    output logic wait_trigger_flag
);
    import trgseq_pkg::*;

    logic cont_en;
    trgseq_func_t func;
    logic [6:0] cnt_curr;
    logic [6:0] cnt_volt;
    logic [DATA_W-1:0] hyst;
    logic [DATA_W-1:0] level;
    trgseq_acq_cfg_t acq_cfg;
    logic tran_armed;
    logic tran_rearm;
    typedef enum logic {ACQ_IDLE, ACQ_ARMED} trgseq_acq_state_t;
    trgseq_acq_state_t acq_state;
    logic [6:0] acq_left;
    logic [DATA_W-1:0] samp;
    logic below_seen;
    logic above_seen;
    logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
    logic [BUF_AW-1:0] buf_wptr;
    logic [BUF_AW-1:0] buf_rptr;
    logic next_tran_armed;
    logic next_acq_armed;

    // command decode
    logic cmd_wr;
    logic do_abort;
    logic do_reset;
    logic init_tran;
    logic init_acq;
    logic bus_tran;
    logic bus_acq;
    assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
    assign do_reset = cmd_wr && reg_wdata[CMD_RESET];
    // reset and recall both abort
    assign do_abort = cmd_wr && (reg_wdata[CMD_ABORT] || reg_wdata[CMD_RESET]
                      || reg_wdata[CMD_RECALL]);
    // sequence numbers 1 and 2 map to transient and acquire
    assign init_tran = cmd_wr && reg_wdata[CMD_INIT_SEQ1];
    assign init_acq = cmd_wr && reg_wdata[CMD_INIT_SEQ2];
    // transient listens to the bus only
    assign bus_tran = cmd_wr && reg_wdata[CMD_TRIG_SEQ1];
    assign bus_acq = cmd_wr && reg_wdata[CMD_TRIG_SEQ2];

    logic acq_armed;
    assign acq_armed = (acq_state == ACQ_ARMED);

    // hysteresis band around the trigger level
    logic signed [DATA_W+1:0] band_hi;
    logic signed [DATA_W+1:0] band_lo;
    logic signed [DATA_W+1:0] samp_s;
    assign band_hi = $signed({2'b00, level}) + $signed({3'b000, hyst[DATA_W-1:1]});
    assign band_lo = $signed({2'b00, level}) - $signed({3'b000, hyst[DATA_W-1:1]});
    assign samp_s = $signed({2'b00, samp});

    logic pos_hit;
    logic neg_hit;
    logic int_trig;
    assign pos_hit = below_seen && (samp_s > band_hi);
    assign neg_hit = above_seen && (samp_s < band_lo);
    assign int_trig = ((acq_cfg.slope != SL_NEG) && pos_hit)
                      || ((acq_cfg.slope != SL_POS) && neg_hit);

    // accepted triggers, only while armed
    logic tran_fire;
    logic acq_fire;
    assign tran_fire = bus_tran && tran_armed && !do_abort;
    assign acq_fire = acq_armed && !do_abort && !init_acq
                      && ((acq_cfg.source == SRC_BUS) ? bus_acq : int_trig);

    logic [6:0] cnt_sel;
    always_comb begin
        case (func)
            FN_CURR: cnt_sel = cnt_curr;
            FN_VOLT: cnt_sel = cnt_volt;
            default: cnt_sel = CNT_AUX;
        endcase
    end

    // next armed states
    always_comb begin
        next_tran_armed = tran_armed;
        if (do_abort) begin
            // the reset command turns continuous mode off, so it never re-arms
            next_tran_armed = cont_en && !do_reset;
        end else if (init_tran || tran_rearm) begin
            next_tran_armed = 1'b1;
        end else if (tran_fire) begin
            next_tran_armed = 1'b0;
        end
        next_acq_armed = acq_armed;
        if (do_abort) begin
            next_acq_armed = 1'b0;
        end else if (init_acq) begin
            next_acq_armed = 1'b1;
        end else if (acq_fire && (acq_left == CNT_MIN)) begin
            next_acq_armed = 1'b0;
        end
    end

    // settings, restored by the reset command
    always_ff @(posedge ref_clk) begin
        if (!rst_n || do_reset) begin
            cont_en <= 1'b0;
            func <= FN_VOLT;
            cnt_curr <= CNT_MIN;
            cnt_volt <= CNT_MIN;
            hyst <= HYST_RST;
            level <= LEVEL_RST;
            acq_cfg <= '{slope: SL_POS, source: SRC_INTERNAL};
        end else if (reg_wr) begin
            if (reg_addr == REG_CONT) begin
                cont_en <= reg_wdata[0];
            end else if (reg_addr == REG_FUNC) begin
                if (reg_wdata[1:0] <= 2'h2) begin
                    func <= trgseq_func_t'(reg_wdata[1:0]);
                end
            end else if (reg_addr == REG_CNT_CURR) begin
                if (reg_wdata >= 16'(CNT_MIN) && reg_wdata <= 16'(CNT_MAX)) begin
                    cnt_curr <= reg_wdata[6:0];
                end
            end else if (reg_addr == REG_CNT_VOLT) begin
                if (reg_wdata >= 16'(CNT_MIN) && reg_wdata <= 16'(CNT_MAX)) begin
                    cnt_volt <= reg_wdata[6:0];
                end
            end else if (reg_addr == REG_HYST) begin
                hyst <= reg_wdata;
            end else if (reg_addr == REG_LEVEL) begin
                level <= reg_wdata;
            end else if (reg_addr == REG_ACQ_CFG) begin
                if (reg_wdata[2:1] <= 2'h2) begin
                    acq_cfg <= trgseq_acq_cfg_t'(reg_wdata[2:0]);
                end
            end
        end
    end

    // transient sequence and its continuous re-arm
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tran_armed <= 1'b0;
            tran_rearm <= 1'b0;
        end else begin
            tran_armed <= next_tran_armed;
            tran_rearm <= tran_fire && cont_en;
        end
    end

    // acquire sequence state and remaining count
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acq_state <= ACQ_IDLE;
            acq_left <= CNT_MIN;
        end else begin
            acq_state <= next_acq_armed ? ACQ_ARMED : ACQ_IDLE;
            if (init_acq && !do_abort) begin
                acq_left <= cnt_sel;
            end else if (acq_fire && acq_left != CNT_MIN) begin
                acq_left <= acq_left - CNT_MIN;
            end
        end
    end

    // sample of the selected quantity and crossing memory
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            samp <= '0;
            below_seen <= 1'b0;
            above_seen <= 1'b0;
        end else begin
            samp <= (func == FN_CURR) ? curr_sample :
                    (func == FN_AUX) ? aux_voltmeter_input : volt_sample;
            if (acq_fire || init_acq) begin
                below_seen <= 1'b0; // fresh excursion needed
                above_seen <= 1'b0;
            end else begin
                if (samp_s < band_lo) begin
                    below_seen <= 1'b1;
                end else if (pos_hit) begin
                    below_seen <= 1'b0;
                end
                if (samp_s > band_hi) begin
                    above_seen <= 1'b1;
                end else if (neg_hit) begin
                    above_seen <= 1'b0;
                end
            end
        end
    end

    // measurement buffer
    always_ff @(posedge ref_clk) begin
        if (acq_fire) begin
            buf_mem[buf_wptr] <= samp;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            buf_wptr <= '0;
            buf_rptr <= '0;
        end else begin
            if (init_acq && !do_abort) begin
                buf_wptr <= '0;
            end else if (acq_fire) begin
                buf_wptr <= buf_wptr + 1'b1;
            end
            if (reg_wr && reg_addr == REG_BUF_INDEX) begin
                buf_rptr <= reg_wdata[BUF_AW-1:0];
            end
        end
    end

    // output strobes and flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            level_apply <= 1'b0;
            level_restore <= 1'b0;
            meas_strobe <= 1'b0;
            meas_rec <= '0;
            wait_trigger_flag <= 1'b0;
        end else begin
            level_apply <= tran_fire;
            level_restore <= do_abort;
            meas_strobe <= acq_fire;
            if (acq_fire) begin
                meas_rec <= '{func: func, value: samp};
            end
            wait_trigger_flag <= next_tran_armed || next_acq_armed;
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == REG_CONT) begin
                reg_rdata <= {15'h0000, cont_en};
            end else if (reg_addr == REG_FUNC) begin
                reg_rdata <= {14'h0000, func};
            end else if (reg_addr == REG_CNT_CURR) begin
                reg_rdata <= {9'h000, cnt_curr};
            end else if (reg_addr == REG_CNT_VOLT) begin
                reg_rdata <= {9'h000, cnt_volt};
            end else if (reg_addr == REG_CNT_AUX) begin
                reg_rdata <= {9'h000, CNT_AUX};
            end else if (reg_addr == REG_HYST) begin
                reg_rdata <= hyst;
            end else if (reg_addr == REG_LEVEL) begin
                reg_rdata <= level;
            end else if (reg_addr == REG_ACQ_CFG) begin
                reg_rdata <= {13'h0000, acq_cfg};
            end else if (reg_addr == REG_OPER_COND) begin
                reg_rdata <= 16'(wait_trigger_flag) << WAIT_FLAG_BIT;
            end else if (reg_addr == REG_ACQ_STAT) begin
                reg_rdata <= (16'(acq_left) << CNT_LSB) | (16'(acq_armed) << ARM_ACQ_BIT)
                             | (16'(tran_armed) << ARM_TRAN_BIT);
            end else if (reg_addr == REG_BUF_INDEX) begin
                reg_rdata <= {9'h000, buf_wptr};
            end else if (reg_addr == REG_BUF_DATA) begin
                reg_rdata <= buf_mem[buf_rptr];
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    // checks
    property p_flag_or;
        @(posedge ref_clk) disable iff (!rst_n)
        wait_trigger_flag == (tran_armed || acq_armed);
    endproperty
    a_flag_or: assert property (p_flag_or) else $error("flag not OR of armed");

    property p_abort_clr;
        @(posedge ref_clk) disable iff (!rst_n)
        do_abort && (!cont_en || do_reset) |=> !wait_trigger_flag && !acq_armed;
    endproperty
    a_abort_clr: assert property (p_abort_clr) else $error("abort left flag");

    property p_abort_cont;
        @(posedge ref_clk) disable iff (!rst_n)
        do_abort && cont_en && !do_reset |=> tran_armed && wait_trigger_flag;
    endproperty
    a_abort_cont: assert property (p_abort_cont) else $error("no re-arm after abort");

    property p_ignore;
        @(posedge ref_clk) disable iff (!rst_n)
        bus_tran && !tran_armed |=> !level_apply;
    endproperty
    a_ignore: assert property (p_ignore) else $error("unarmed trigger acted");

    property p_apply;
        @(posedge ref_clk) disable iff (!rst_n)
        bus_tran && tran_armed && !do_abort |=> level_apply ##1 !level_apply;
    endproperty
    a_apply: assert property (p_apply) else $error("level change missing");

    property p_rearm;
        @(posedge ref_clk) disable iff (!rst_n)
        tran_fire && cont_en |=> !tran_armed ##1 tran_armed;
    endproperty
    a_rearm: assert property (p_rearm) else $error("continuous re-arm missing");

    property p_restore;
        @(posedge ref_clk) disable iff (!rst_n)
        do_abort |=> level_restore && !level_apply;
    endproperty
    a_restore: assert property (p_restore) else $error("abort did not restore");

    property p_cnt_range;
        @(posedge ref_clk) disable iff (!rst_n)
        cnt_curr >= CNT_MIN && cnt_curr <= CNT_MAX && cnt_volt >= CNT_MIN
        && cnt_volt <= CNT_MAX;
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("count out of range");

    property p_done;
        @(posedge ref_clk) disable iff (!rst_n)
        acq_fire && acq_left == CNT_MIN |=> !acq_armed ##1 !meas_strobe;
    endproperty
    a_done: assert property (p_done) else $error("acquire not idle");
endmodule

// [tb/trgseq_host.sv]
`timescale 1ns/1ps
module trgseq_host (
    // clock
    input wire logic ref_clk,
    // register port
    output logic [trgseq_pkg::ADDR_W-1:0] reg_addr,
    output logic [trgseq_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [trgseq_pkg::DATA_W-1:0] reg_rdata
);
    import trgseq_pkg::*;
    // bus idle at time zero
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write cycle; released lines show the inverse, not the last value
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // one read cycle; data taken in the single cycle it stands
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask
    // measurement function is chosen before any acquire trigger
    task automatic sel(input trgseq_func_t f, input logic [ADDR_W-1:0] ca, input int n);
        wr(REG_FUNC, {14'h0000, f});
        wr(ca, 16'(n));
    endtask
endmodule

// [tb/test_trgseq_top.sv]
`timescale 1ns/1ps
module test_trgseq_top;
    import trgseq_pkg::*;
    logic ref_clk;
    logic rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] volt_sample;
    logic [DATA_W-1:0] curr_sample;
    logic [DATA_W-1:0] aux_voltmeter_input;
    logic level_apply;
    logic level_restore;
    logic meas_strobe;
    trgseq_meas_t meas_rec;
    logic wait_trigger_flag;
    int failures = 0;
    int compares = 0;
    int n_apply = 0;
    int n_restore = 0;
    int n_meas = 0;
    int e_apply = 0;
    int e_restore = 0;
    int e_meas = 0;
    int cycles = 0;
    logic [DATA_W-1:0] rv;

    trgseq_top u_trgseq_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .volt_sample(volt_sample), .curr_sample(curr_sample),
        .aux_voltmeter_input(aux_voltmeter_input), .level_apply(level_apply),
        .level_restore(level_restore), .meas_strobe(meas_strobe), .meas_rec(meas_rec),
        .wait_trigger_flag(wait_trigger_flag));
    trgseq_host u_trgseq_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // pulse counters and hang limit
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        n_apply <= n_apply + int'(level_apply === 1'b1);
        n_restore <= n_restore + int'(level_restore === 1'b1);
        n_meas <= n_meas + int'(meas_strobe === 1'b1);
        if (cycles == 4000) begin
            failures++;
            conclude();
        end
    end
    // verdict and end of run
    task automatic conclude();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [15:0] e);
        u_trgseq_host.rd(a, rv);
        chk(nm, {2'h0, e}, {2'h0, rv});
    endtask
    task automatic cmd(input int b);
        u_trgseq_host.wr(REG_CMD, 16'h0001 << b);
    endtask
    // flag seen half a cycle after the command edge
    task automatic fchk(input logic e);
        @(negedge ref_clk);
        chk("wait_trigger_flag", {17'h00000, e}, {17'h00000, wait_trigger_flag});
    endtask
    // let pulses land, then compare all pulse counts
    task automatic pulses();
        repeat (5) @(posedge ref_clk);
        chk("level_apply count", 18'(e_apply), 18'(n_apply));
        chk("level_restore count", 18'(e_restore), 18'(n_restore));
        chk("meas_strobe count", 18'(e_meas), 18'(n_meas));
    endtask
    task automatic vset(input logic [15:0] v);
        @(posedge ref_clk);
        volt_sample <= v;
        pulses();
    endtask

    initial begin
        rst_n = 1'b0;
        volt_sample = 16'h005F;
        curr_sample = 16'h1234;
        aux_voltmeter_input = 16'h0ABC;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        // settings after reset and refused values
        rchk("cnt_curr", REG_CNT_CURR, 16'h0001);
        rchk("hyst", REG_HYST, HYST_RST);
        rchk("oper_cond", REG_OPER_COND, 16'h0000);
        u_trgseq_host.wr(REG_CNT_VOLT, 16'h0065);
        rchk("cnt_volt 101", REG_CNT_VOLT, 16'h0001);
        u_trgseq_host.wr(REG_CNT_VOLT, 16'h0064);
        rchk("cnt_volt 100", REG_CNT_VOLT, 16'h0064);
        u_trgseq_host.wr(REG_CNT_AUX, 16'h0002);
        rchk("cnt_aux", REG_CNT_AUX, 16'h0001);
        rchk("unmapped", 4'hD, 16'h0000);
        $display("test settings done");
        // transient sequence
        cmd(CMD_TRIG_SEQ1);
        pulses();
        cmd(CMD_INIT_SEQ1);
        fchk(1'b1);
        rchk("oper_cond armed", REG_OPER_COND, 16'h0020);
        cmd(CMD_TRIG_SEQ2);
        pulses();
        cmd(CMD_TRIG_SEQ1);
        fchk(1'b0);
        e_apply++;
        pulses();
        $display("test transient done");
        // abort, continuous mode, reset and recall
        cmd(CMD_INIT_SEQ1);
        cmd(CMD_ABORT);
        fchk(1'b0);
        e_restore++;
        cmd(CMD_TRIG_SEQ1);
        pulses();
        u_trgseq_host.wr(REG_CONT, 16'h0001);
        cmd(CMD_ABORT);
        fchk(1'b1);
        e_restore++;
        for (int i = 0; i < 2; i++) begin
            cmd(CMD_TRIG_SEQ1);
            e_apply++;
            pulses();
            fchk(1'b1);
        end
        cmd(CMD_RESET);
        fchk(1'b0);
        e_restore++;
        pulses();
        rchk("cont after reset", REG_CONT, 16'h0000);
        rchk("cnt_volt after reset", REG_CNT_VOLT, 16'h0001);
        cmd(CMD_INIT_SEQ1);
        cmd(CMD_RECALL);
        fchk(1'b0);
        e_restore++;
        pulses();
        $display("test abort done");
        // acquire on bus triggers, count of three, then aux input
        u_trgseq_host.sel(FN_CURR, REG_CNT_CURR, 3);
        u_trgseq_host.wr(REG_FUNC, 16'h0003);
        rchk("func curr", REG_FUNC, 16'h0001);
        u_trgseq_host.wr(REG_ACQ_CFG, 16'h0001);
        cmd(CMD_INIT_SEQ1);
        cmd(CMD_INIT_SEQ2);
        cmd(CMD_TRIG_SEQ1);
        e_apply++;
        fchk(1'b1);
        rchk("acq_stat", REG_ACQ_STAT, 16'h0302);
        for (int i = 0; i < 3; i++) begin
            cmd(CMD_TRIG_SEQ2);
            e_meas++;
            pulses();
            chk("meas_rec curr", {FN_CURR, 16'h1234}, meas_rec);
        end
        fchk(1'b0);
        cmd(CMD_TRIG_SEQ2);
        pulses();
        rchk("buffer fill", REG_BUF_INDEX, 16'h0003);
        u_trgseq_host.wr(REG_BUF_INDEX, 16'h0000);
        rchk("buffer word 0", REG_BUF_DATA, 16'h1234);
        u_trgseq_host.sel(FN_AUX, REG_CNT_AUX, 1);
        cmd(CMD_INIT_SEQ2);
        cmd(CMD_TRIG_SEQ2);
        fchk(1'b0);
        e_meas++;
        pulses();
        chk("meas_rec aux", {FN_AUX, 16'h0ABC}, meas_rec);
        $display("test acquire bus done");
        // internal trigger, band 90..110 around level 100
        u_trgseq_host.wr(REG_ACQ_CFG, 16'h0000);
        u_trgseq_host.sel(FN_VOLT, REG_CNT_VOLT, 2);
        u_trgseq_host.wr(REG_LEVEL, 16'h0064);
        u_trgseq_host.wr(REG_HYST, 16'h0014);
        cmd(CMD_INIT_SEQ2);
        vset(16'h0078);
        vset(16'h0050);
        vset(16'h006D);
        e_meas++;
        vset(16'h006F);
        chk("meas_rec volt", {FN_VOLT, 16'h006F}, meas_rec);
        u_trgseq_host.wr(REG_ACQ_CFG, 16'h0002);
        vset(16'h005B);
        e_meas++;
        vset(16'h0059);
        fchk(1'b0);
        // either slope: one rising and one falling crossing, refused slope code
        u_trgseq_host.wr(REG_ACQ_CFG, 16'h0004);
        u_trgseq_host.wr(REG_ACQ_CFG, 16'h0006);
        rchk("acq_cfg either", REG_ACQ_CFG, 16'h0004);
        cmd(CMD_INIT_SEQ2);
        e_meas++;
        vset(16'h006F);
        e_meas++;
        vset(16'h0059);
        fchk(1'b0);
        $display("test internal trigger done");
        conclude();
    end
endmodule
